// file: logic/fcwr_consts.vh
// Constants for the flash command-write and mode-control host controller.
`ifndef FCWR_CONSTS_VH
`define FCWR_CONSTS_VH

`define FCWR_CLK_NS 100
// Pin timings in nanoseconds. The real figures come from the part's timing tables.
`define FCWR_T_SELECT_ACCESS_NS 70
`define FCWR_T_MIN_CLEAR_PULSE_NS 10000
`define FCWR_T_CLEAR_TO_READ_NS 200
`define FCWR_T_WRITE_PULSE_NS 40
`define FCWR_T_BUSY_SETTLE_NS 500
`define FCWR_T_ACCEL_SETTLE_NS 1000

`define FCWR_ADDR_W 23
`define FCWR_DATA_W 16

// Host operation codes on op_in.
`define FCWR_OP_READ 4'h0
`define FCWR_OP_PROG 4'h1
`define FCWR_OP_ERASE_SEC 4'h2
`define FCWR_OP_ERASE_CHIP 4'h3
`define FCWR_OP_BYP_ENTER 4'h4
`define FCWR_OP_BYP_EXIT 4'h5
`define FCWR_OP_ID_ENTER 4'h6
`define FCWR_OP_ID_EXIT 4'h7
`define FCWR_OP_RESET 4'h8
`define FCWR_OP_ACC_ON 4'h9
`define FCWR_OP_ACC_OFF 4'hA

// Command bus cycle words. Plain defaults, replaceable per part.
`define FCWR_UNLOCK_ADDR1 23'h00_0555
`define FCWR_UNLOCK_ADDR2 23'h00_02AA
`define FCWR_CODE_UNLOCK1 8'hAA
`define FCWR_CODE_UNLOCK2 8'h55
`define FCWR_CODE_PROG 8'hA0
`define FCWR_CODE_ERASE 8'h80
`define FCWR_CODE_ERASE_SEC 8'h30
`define FCWR_CODE_ERASE_CHIP 8'h10
`define FCWR_CODE_BYP_ENTER 8'h20
`define FCWR_CODE_BYP_EXIT1 8'h90
`define FCWR_CODE_BYP_EXIT2 8'h00
`define FCWR_CODE_ID_ENTER 8'h90
`define FCWR_CODE_ID_EXIT 8'hF0

`endif

// file: logic/fcwr_timer.v
// Down-counting delay timer for the flash host controller.
module fcwr_timer (
  input wire sys_clk_in,
  input wire resetn_in,
  input wire load_in,
  input wire [7:0] count_in,
  output reg zero_out
);
  reg [7:0] cnt_r;

  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_r <= 8'h00;
      zero_out <= 1'b1;
    end else if (load_in) begin
      cnt_r <= count_in;
      zero_out <= (count_in == 8'h00);
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
      zero_out <= (cnt_r == 8'h01);
    end
  end
endmodule // fcwr_timer

// file: logic/fcwr_host.v
// Host controller driving an asynchronous NOR flash through its select, gate, strobe, reset and accel pins.
`include "fcwr_consts.vh"
module fcwr_host (
  input wire sys_clk_in,
  input wire resetn_in,
  input wire cmd_valid_in,
  input wire [3:0] op_in,
  input wire [22:0] addr_in,
  input wire [15:0] wdata_in,
  output reg busy_out,
  output reg done_out,
  output reg refused_out,
  output reg retried_out,
  output reg [15:0] rdata_out,
  output reg short_prog_out,
  output reg id_mode_out,
  output reg lower_half_select_n_out,
  output reg oe_n_out,
  output reg we_n_out,
  output reg clear_n_out,
  output reg protect_accel_pin_out,
  output reg accel_high_level_out,
  output reg [22:0] addr_out,
  output reg [15:0] data_bus_lines_out,
  output reg data_bus_lines_oe_out,
  input wire [15:0] data_bus_lines_in,
  input wire ready_busy_n_in
);
  function [7:0] ns2cyc;
    input integer ns;
    integer c;
    begin
      c = (ns + `FCWR_CLK_NS - 1) / `FCWR_CLK_NS;
      if (c < 1) c = 1;
      ns2cyc = c[7:0];
    end
  endfunction

  localparam [7:0] CYC_SEL = ns2cyc(`FCWR_T_SELECT_ACCESS_NS);
  localparam [7:0] CYC_CLR = ns2cyc(`FCWR_T_MIN_CLEAR_PULSE_NS);
  localparam [7:0] CYC_REC = ns2cyc(`FCWR_T_CLEAR_TO_READ_NS);
  localparam [7:0] CYC_WE = ns2cyc(`FCWR_T_WRITE_PULSE_NS);
  localparam [7:0] CYC_BSY = ns2cyc(`FCWR_T_BUSY_SETTLE_NS);
  localparam [7:0] CYC_ACC = ns2cyc(`FCWR_T_ACCEL_SETTLE_NS);

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_WSET = 4'h1;
  localparam [3:0] S_WPULSE = 4'h2;
  localparam [3:0] S_WHOLD = 4'h3;
  localparam [3:0] S_RACC = 4'h4;
  localparam [3:0] S_SETTLE = 4'h5;
  localparam [3:0] S_POLL = 4'h6;
  localparam [3:0] S_CLOW = 4'h7;
  localparam [3:0] S_CRDY = 4'h8;
  localparam [3:0] S_CREC = 4'h9;
  localparam [3:0] S_ACC = 4'hA;

  // Bus cycle word: {address select[1:0], code[7:0]}; select 0/1 unlock, 2 user addr, 3 user addr+data.
  function [9:0] seq_word;
    input [3:0] op;
    input [2:0] idx;
    begin
      seq_word = {2'd0, `FCWR_CODE_UNLOCK1};
      if (idx == 3'd1 || idx == 3'd4) seq_word = {2'd1, `FCWR_CODE_UNLOCK2};
      case (op)
        `FCWR_OP_PROG: begin
          if (idx == 3'd2) seq_word = {2'd0, `FCWR_CODE_PROG};
          if (idx == 3'd3) seq_word = {2'd3, 8'h00};
        end
        `FCWR_OP_ERASE_SEC, `FCWR_OP_ERASE_CHIP: begin
          if (idx == 3'd2) seq_word = {2'd0, `FCWR_CODE_ERASE};
          if (idx == 3'd5) seq_word = (op == `FCWR_OP_ERASE_SEC) ? {2'd2, `FCWR_CODE_ERASE_SEC} :
                                                                   {2'd0, `FCWR_CODE_ERASE_CHIP};
        end
        `FCWR_OP_BYP_ENTER: if (idx == 3'd2) seq_word = {2'd0, `FCWR_CODE_BYP_ENTER};
        `FCWR_OP_BYP_EXIT: seq_word = {2'd0, (idx == 3'd0) ? `FCWR_CODE_BYP_EXIT1 : `FCWR_CODE_BYP_EXIT2};
        `FCWR_OP_ID_ENTER: if (idx == 3'd2) seq_word = {2'd0, `FCWR_CODE_ID_ENTER};
        `FCWR_OP_ID_EXIT: seq_word = {2'd0, `FCWR_CODE_ID_EXIT};
        default: seq_word = {2'd0, `FCWR_CODE_UNLOCK1};
      endcase
    end
  endfunction

  function [2:0] seq_last;
    input [3:0] op;
    begin
      case (op)
        `FCWR_OP_PROG: seq_last = 3'd3;
        `FCWR_OP_ERASE_SEC, `FCWR_OP_ERASE_CHIP: seq_last = 3'd5;
        `FCWR_OP_BYP_ENTER, `FCWR_OP_ID_ENTER: seq_last = 3'd2;
        `FCWR_OP_BYP_EXIT: seq_last = 3'd1;
        default: seq_last = 3'd0;
      endcase
    end
  endfunction

  function is_embedded;
    input [3:0] op;
    begin
      is_embedded = (op == `FCWR_OP_PROG) || (op == `FCWR_OP_ERASE_SEC) || (op == `FCWR_OP_ERASE_CHIP);
    end
  endfunction

  reg [3:0] state_r;
  reg [3:0] op_r;
  reg [22:0] uaddr_r;
  reg [15:0] udata_r;
  reg [2:0] step_r;
  reg bypass_r;
  reg emb_valid_r;
  reg [3:0] emb_op_r;
  reg [22:0] emb_addr_r;
  reg [15:0] emb_data_r;
  reg retry_r;
  reg tload_r;
  reg [7:0] tval_r;
  wire tzero;
  wire [9:0] word;
  wire tdone;
  wire short_mode;

  assign word = seq_word(op_r, step_r);
  assign tdone = tzero && !tload_r;
  assign short_mode = bypass_r || accel_high_level_out;

  fcwr_timer u_timer (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .load_in(tload_r),
    .count_in(tval_r),
    .zero_out(tzero)
  );

  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= S_IDLE;
      op_r <= 4'h0;
      uaddr_r <= 23'h00_0000;
      udata_r <= 16'h0000;
      step_r <= 3'd0;
      bypass_r <= 1'b0;
      emb_valid_r <= 1'b0;
      emb_op_r <= 4'h0;
      emb_addr_r <= 23'h00_0000;
      emb_data_r <= 16'h0000;
      retry_r <= 1'b0;
      tload_r <= 1'b0;
      tval_r <= 8'h00;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      refused_out <= 1'b0;
      retried_out <= 1'b0;
      rdata_out <= 16'h0000;
      short_prog_out <= 1'b0;
      id_mode_out <= 1'b0;
      lower_half_select_n_out <= 1'b1;
      oe_n_out <= 1'b1;
      we_n_out <= 1'b1;
      clear_n_out <= 1'b1;
      protect_accel_pin_out <= 1'b1;
      accel_high_level_out <= 1'b0;
      addr_out <= 23'h00_0000;
      data_bus_lines_out <= 16'h0000;
      data_bus_lines_oe_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      refused_out <= 1'b0;
      retried_out <= 1'b0;
      tload_r <= 1'b0;
      // Protect level stays at logic high so the outer boot sectors are always writable.
      protect_accel_pin_out <= 1'b1;
      short_prog_out <= short_mode;
      case (state_r)
        S_IDLE: begin
          // Select and reset held high between requests keeps the device in standby.
          lower_half_select_n_out <= 1'b1;
          oe_n_out <= 1'b1;
          data_bus_lines_oe_out <= 1'b0;
          if (cmd_valid_in) begin
            op_r <= op_in;
            uaddr_r <= addr_in;
            udata_r <= wdata_in;
            // Under the accel level only reads, two-cycle programs, reset and accel-off are issued.
            if (accel_high_level_out && !(op_in == `FCWR_OP_READ || op_in == `FCWR_OP_PROG ||
                op_in == `FCWR_OP_RESET || op_in == `FCWR_OP_ACC_OFF)) begin
              refused_out <= 1'b1;
            end else if (op_in > `FCWR_OP_ACC_OFF || (op_in == `FCWR_OP_ACC_ON && accel_high_level_out)) begin
              refused_out <= 1'b1;
            end else begin
              busy_out <= 1'b1;
              case (op_in)
                `FCWR_OP_READ: begin
                  lower_half_select_n_out <= 1'b0;
                  oe_n_out <= 1'b0;
                  addr_out <= addr_in;
                  tload_r <= 1'b1;
                  tval_r <= CYC_SEL;
                  state_r <= S_RACC;
                end
                `FCWR_OP_RESET: begin
                  clear_n_out <= 1'b0;
                  retry_r <= emb_valid_r && !ready_busy_n_in;
                  tload_r <= 1'b1;
                  tval_r <= CYC_CLR;
                  state_r <= S_CLOW;
                end
                `FCWR_OP_ACC_ON, `FCWR_OP_ACC_OFF: begin
                  accel_high_level_out <= (op_in == `FCWR_OP_ACC_ON);
                  tload_r <= 1'b1;
                  tval_r <= CYC_ACC;
                  state_r <= S_ACC;
                end
                default: begin
                  // Short-program mode skips the two unlock cycles of a word program.
                  step_r <= (op_in == `FCWR_OP_PROG && short_mode) ? 3'd2 : 3'd0;
                  if (is_embedded(op_in)) begin
                    emb_op_r <= op_in;
                    emb_addr_r <= addr_in;
                    emb_data_r <= wdata_in;
                  end
                  state_r <= S_WSET;
                end
              endcase
            end
          end
        end
        S_WSET: begin
          lower_half_select_n_out <= 1'b0;
          oe_n_out <= 1'b1;
          addr_out <= (word[9:8] == 2'd0) ? `FCWR_UNLOCK_ADDR1 : (word[9:8] == 2'd1) ? `FCWR_UNLOCK_ADDR2 : uaddr_r;
          data_bus_lines_out <= (word[9:8] == 2'd3) ? udata_r : {8'h00, word[7:0]};
          data_bus_lines_oe_out <= 1'b1;
          tload_r <= 1'b1;
          tval_r <= CYC_WE;
          state_r <= S_WPULSE;
        end
        S_WPULSE: begin
          we_n_out <= 1'b0;
          if (tdone) begin
            state_r <= S_WHOLD;
          end
        end
        S_WHOLD: begin
          we_n_out <= 1'b1;
          lower_half_select_n_out <= 1'b1;
          if (step_r != seq_last(op_r)) begin
            step_r <= step_r + 3'd1;
            state_r <= S_WSET;
          end else begin
            data_bus_lines_oe_out <= 1'b0;
            if (op_r == `FCWR_OP_BYP_ENTER) bypass_r <= 1'b1;
            if (op_r == `FCWR_OP_BYP_EXIT) bypass_r <= 1'b0;
            if (op_r == `FCWR_OP_ID_ENTER) id_mode_out <= 1'b1;
            if (op_r == `FCWR_OP_ID_EXIT) id_mode_out <= 1'b0;
            if (is_embedded(op_r)) begin
              emb_valid_r <= 1'b1;
              tload_r <= 1'b1;
              tval_r <= CYC_BSY;
              state_r <= S_SETTLE;
            end else begin
              busy_out <= 1'b0;
              done_out <= 1'b1;
              state_r <= S_IDLE;
            end
          end
        end
        S_RACC: begin
          // Query-mode reads use the same cycle as array reads.
          if (tdone) begin
            rdata_out <= data_bus_lines_in;
            lower_half_select_n_out <= 1'b1;
            oe_n_out <= 1'b1;
            busy_out <= 1'b0;
            done_out <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_SETTLE: begin
          // Select stays released while the device runs its embedded operation.
          if (tdone) begin
            state_r <= S_POLL;
          end
        end
        S_POLL: begin
          if (ready_busy_n_in) begin
            emb_valid_r <= 1'b0;
            busy_out <= 1'b0;
            done_out <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_CLOW: begin
          // Release only after the full minimum pulse; a shorter pulse leaves the device undefined.
          if (tdone) begin
            clear_n_out <= 1'b1;
            state_r <= S_CRDY;
          end
        end
        S_CRDY: begin
          if (ready_busy_n_in) begin
            tload_r <= 1'b1;
            tval_r <= CYC_REC;
            state_r <= S_CREC;
          end
        end
        S_CREC: begin
          if (tdone) begin
            // The device is back in read-array mode, so mode tracking restarts.
            bypass_r <= 1'b0;
            id_mode_out <= 1'b0;
            emb_valid_r <= 1'b0;
            if (retry_r) begin
              retry_r <= 1'b0;
              retried_out <= 1'b1;
              op_r <= emb_op_r;
              uaddr_r <= emb_addr_r;
              udata_r <= emb_data_r;
              step_r <= (emb_op_r == `FCWR_OP_PROG && accel_high_level_out) ? 3'd2 : 3'd0;
              state_r <= S_WSET;
            end else begin
              busy_out <= 1'b0;
              done_out <= 1'b1;
              state_r <= S_IDLE;
            end
          end
        end
        S_ACC: begin
          if (tdone) begin
            busy_out <= 1'b0;
            done_out <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule // fcwr_host

// file: dv/fcwr_host_chk.sv
// Assertions on the flash host controller's pins and command port.
module fcwr_host_chk (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic cmd_valid_in,
  input wire logic [3:0] op_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic refused_out,
  input wire logic lower_half_select_n_out,
  input wire logic oe_n_out,
  input wire logic we_n_out,
  input wire logic clear_n_out,
  input wire logic protect_accel_pin_out,
  input wire logic data_bus_lines_oe_out,
  input wire logic accel_high_level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  // Counts low cycles of the clear pin so its width can be judged on release.
  logic [7:0] low_cnt_r;
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) low_cnt_r <= 8'h00;
    else if (clear_n_out) low_cnt_r <= 8'h00;
    else if (low_cnt_r != 8'hFF) low_cnt_r <= low_cnt_r + 8'h01;
  end
  sequence s_write_bus;
    !lower_half_select_n_out && oe_n_out;
  endsequence
  sequence s_read_bus;
    !lower_half_select_n_out && we_n_out;
  endsequence
  chk_write_qualified: assert property (!we_n_out |-> s_write_bus)
    else $error("strobe low without select low and gate high");
  chk_read_qualified: assert property (!oe_n_out |-> s_read_bus)
    else $error("gate low without select low and strobe high");
  chk_protect_high: assert property (!we_n_out |-> protect_accel_pin_out)
    else $error("protect pin low during a write");
  chk_data_driven: assert property (!we_n_out |-> data_bus_lines_oe_out)
    else $error("strobe low without write data driven");
  chk_accel_refuse: assert property (accel_high_level_out && cmd_valid_in && !busy_out &&
    !(op_in inside {4'h0, 4'h1, 4'h8, 4'hA}) |=> refused_out && !busy_out)
    else $error("operation taken under high accel level");
  chk_recovery_wait: assert property ($rose(clear_n_out) |-> oe_n_out [*2])
    else $error("read too soon after clear release");
  chk_pulse_width: assert property ($rose(clear_n_out) |-> low_cnt_r >= 8'h64)
    else $error("clear pulse too short");
  chk_bad_op_refused: assert property (cmd_valid_in && !busy_out && op_in > 4'hA |=> refused_out && !busy_out)
    else $error("unknown operation not refused");
  chk_done_single: assert property (done_out |-> !busy_out ##1 !done_out)
    else $error("done not a single pulse");
endmodule // fcwr_host_chk
bind fcwr_host fcwr_host_chk i_fcwr_host_chk (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
  .cmd_valid_in(cmd_valid_in), .op_in(op_in), .busy_out(busy_out), .done_out(done_out),
  .refused_out(refused_out), .lower_half_select_n_out(lower_half_select_n_out), .oe_n_out(oe_n_out),
  .we_n_out(we_n_out), .clear_n_out(clear_n_out), .protect_accel_pin_out(protect_accel_pin_out),
  .accel_high_level_out(accel_high_level_out), .data_bus_lines_oe_out(data_bus_lines_oe_out));

// file: dv/fcwr_flash_model.sv
// Behavioural model of the flash device as seen at its pins.
`include "fcwr_consts.vh"
module fcwr_flash_model #(
  parameter int ACC_NS = `FCWR_T_SELECT_ACCESS_NS,
  parameter int BUSY_NS = 3000,
  parameter int RDY_NS = 2000,
  parameter int MIN_CLR_NS = `FCWR_T_MIN_CLEAR_PULSE_NS,
  parameter logic [15:0] ID_WORD = 16'h3C5A // Arbitrary value.
) (
  input wire logic sel_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic clr_n_in,
  input wire logic accel_in,
  input wire logic [22:0] addr_in,
  input wire logic [15:0] data_in,
  output logic [15:0] dq_out,
  output logic rdy_out = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:255];
  logic byp_r = 1'b0;
  logic id_r = 1'b0;
  logic busy_r = 1'b0;
  logic valid_r = 1'b0;
  logic wq = 1'b0;
  logic [2:0] st_r = 3'h0;
  logic [15:0] last_r = 16'h0000;
  int wc, viol, gen, agen;
  time fell_t = 0;
  wire byp = byp_r | accel_in;
  wire [15:0] word = id_r ? ID_WORD : mem[addr_in[7:0]];
  wire drive = !sel_n_in && !oe_n_in && clr_n_in && valid_r;
  // A released bus shows the inverse of its last word, so stale data never reads as good.
  assign dq_out = drive ? word : ~last_r;
  always @* if (drive) last_r = word;
  initial foreach (mem[i]) mem[i] = 16'hFFFF;
  always @(sel_n_in or addr_in) begin
    agen++;
    valid_r = 1'b0;
    arm(agen);
  end
  task automatic arm(input int g);
    fork begin
      #(ACC_NS);
      if (g == agen) valid_r = 1'b1;
    end join_none
  endtask
  task automatic fin(input int ns, input int k, input logic [22:0] a, input logic [15:0] d);
    int g;
    gen++;
    g = gen;
    busy_r = 1'b1;
    rdy_out = 1'b0;
    fork begin
      #(ns);
      if (g == gen) begin
        if (k == 1) mem[a[7:0]] = mem[a[7:0]] & d;
        if (k == 2) for (int i = 0; i < 16; i++) mem[{a[7:4], 4'(i)}] = 16'hFFFF;
        if (k == 3) foreach (mem[i]) mem[i] = 16'hFFFF;
        busy_r = 1'b0;
        rdy_out = 1'b1;
      end
    end join_none
  endtask
  task automatic take(input logic [22:0] a, input logic [15:0] d);
    logic [7:0] c;
    c = d[7:0];
    wc++;
    case (st_r)
      3'h0: begin
        if (c == `FCWR_CODE_ID_EXIT) id_r = 1'b0;
        st_r = c == `FCWR_CODE_UNLOCK1 ? 3'h1 : byp && c == `FCWR_CODE_PROG ? 3'h3 :
          byp && c == `FCWR_CODE_BYP_EXIT1 ? 3'h7 : 3'h0;
      end
      3'h1: st_r = c == `FCWR_CODE_UNLOCK2 ? 3'h2 : 3'h0;
      3'h2: begin
        if (c == `FCWR_CODE_ID_ENTER) id_r = 1'b1;
        if (c == `FCWR_CODE_BYP_ENTER) byp_r = 1'b1;
        st_r = c == `FCWR_CODE_PROG ? 3'h3 : c == `FCWR_CODE_ERASE ? 3'h4 : 3'h0;
      end
      3'h3: begin
        fin(BUSY_NS, 1, a, d);
        st_r = 3'h0;
      end
      3'h4: st_r = c == `FCWR_CODE_UNLOCK1 ? 3'h5 : 3'h0;
      3'h5: st_r = c == `FCWR_CODE_UNLOCK2 ? 3'h6 : 3'h0;
      3'h6: begin
        if (c == `FCWR_CODE_ERASE_SEC) fin(BUSY_NS, 2, a, d);
        if (c == `FCWR_CODE_ERASE_CHIP) fin(BUSY_NS, 3, a, d);
        st_r = 3'h0;
      end
      default: begin
        if (c == `FCWR_CODE_BYP_EXIT2) byp_r = 1'b0;
        st_r = 3'h0;
      end
    endcase
  endtask
  // Qualify the cycle while the strobe falls: select may rise in the same step as the strobe.
  always @(negedge we_n_in) wq = !sel_n_in && oe_n_in && clr_n_in && !busy_r;
  always @(posedge we_n_in) begin
    if (wq && clr_n_in) take(addr_in, data_in);
    wq = 1'b0;
  end
  always @(negedge clr_n_in) begin
    fell_t = $time;
    st_r = 3'h0;
    byp_r = 1'b0;
    id_r = 1'b0;
    if (busy_r) fin(RDY_NS, 0, 23'h00_0000, 16'h0000);
  end
  always @(posedge clr_n_in) if (fell_t != 0 && $time - fell_t < MIN_CLR_NS) viol++;
endmodule // fcwr_flash_model

// file: dv/fcwr_host_tb.sv
// Self-checking bench for the flash host controller against the device model.
module fcwr_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] ID_W = 16'h3C5A;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic valid = 1'b0;
  logic [3:0] opc = 4'h0;
  logic [22:0] adr = 23'h00_0000;
  logic [15:0] wd = 16'h0000;
  logic rf;
  int error_cnt = 0;
  int tests_run = 0;
  wire busy, done, refd, short_prog, id_mode, sel_n, oe_n, we_n, clr_n, accel, rdy;
  wire [15:0] rdata, dq, hdata;
  wire [22:0] faddr;
  always #50 clk = ~clk;
  fcwr_host i_fcwr_host (.sys_clk_in(clk), .resetn_in(rst_n), .cmd_valid_in(valid), .op_in(opc),
    .addr_in(adr), .wdata_in(wd), .busy_out(busy), .done_out(done), .refused_out(refd), .retried_out(),
    .rdata_out(rdata), .short_prog_out(short_prog), .id_mode_out(id_mode), .lower_half_select_n_out(sel_n),
    .oe_n_out(oe_n), .we_n_out(we_n), .clear_n_out(clr_n), .protect_accel_pin_out(),
    .accel_high_level_out(accel), .addr_out(faddr), .data_bus_lines_out(hdata), .data_bus_lines_oe_out(),
    .data_bus_lines_in(dq), .ready_busy_n_in(rdy));
  fcwr_flash_model #(.ID_WORD(ID_W)) i_fcwr_flash_model (.sel_n_in(sel_n), .oe_n_in(oe_n), .we_n_in(we_n),
    .clr_n_in(clr_n), .accel_in(accel), .addr_in(faddr), .data_in(hdata), .dq_out(dq), .rdy_out(rdy));
  task chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  function automatic logic [15:0] wcs();
    return 16'(i_fcwr_flash_model.wc);
  endfunction
  // One extra cycle after completion lets the lagging mode flags settle.
  task req(input logic [3:0] o, input logic [22:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    valid = 1'b1;
    opc = o;
    adr = a;
    wd = d;
    @(negedge clk);
    valid = 1'b0;
    while (done !== 1'b1 && refd !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 5000) begin
      error_cnt++;
      $display("[FAIL] %0t request never answered", $time);
      report_and_stop();
    end
    rf = refd;
    @(negedge clk);
  endtask
  task rd(input logic [22:0] a, input logic [15:0] e);
    req(4'h0, a, 16'h0000);
    chk(rdata, e);
  endtask
  task t_program;
    logic [15:0] w;
    w = wcs();
    req(4'h1, 23'h00_0010, 16'hA5C3);
    chk(wcs() - w, 16'h0004);
    rd(23'h00_0010, 16'hA5C3);
  endtask
  task t_bypass;
    logic [15:0] w;
    req(4'h4, 23'h00_0000, 16'h0000);
    chk(short_prog, 1'b1);
    w = wcs();
    req(4'h1, 23'h00_0020, 16'h1234);
    chk(wcs() - w, 16'h0002);
    req(4'h5, 23'h00_0000, 16'h0000);
    chk(short_prog, 1'b0);
  endtask
  task t_accel;
    logic [15:0] w;
    req(4'h9, 23'h00_0000, 16'h0000);
    chk({short_prog, accel}, 2'h3);
    w = wcs();
    req(4'h1, 23'h00_0040, 16'h00FF);
    chk(wcs() - w, 16'h0002);
    req(4'h2, 23'h00_0040, 16'h0000);
    chk(rf, 1'b1);
    req(4'hA, 23'h00_0000, 16'h0000);
    chk({short_prog, accel}, 2'h0);
    w = wcs();
    req(4'h1, 23'h00_0041, 16'h0F0F);
    chk(wcs() - w, 16'h0004);
  endtask
  task t_erase;
    logic [15:0] w;
    w = wcs();
    req(4'h2, 23'h00_0012, 16'h0000);
    chk(wcs() - w, 16'h0006);
    req(4'h2, 23'h00_0045, 16'h0000);
    rd(23'h00_0010, 16'hFFFF);
    rd(23'h00_0041, 16'hFFFF);
    rd(23'h00_0020, 16'h1234);
    req(4'h3, 23'h00_0000, 16'h0000);
    rd(23'h00_0020, 16'hFFFF);
  endtask
  task t_id_reset;
    req(4'h6, 23'h00_0000, 16'h0000);
    chk(id_mode, 1'b1);
    rd(23'h00_0000, ID_W);
    req(4'h8, 23'h00_0000, 16'h0000);
    chk(16'(i_fcwr_flash_model.viol), 16'h0000);
    chk(id_mode, 1'b0);
    rd(23'h00_0000, 16'hFFFF);
    req(4'h6, 23'h00_0000, 16'h0000);
    req(4'h7, 23'h00_0000, 16'h0000);
    rd(23'h00_0000, 16'hFFFF);
  endtask
  task t_refuse;
    for (int o = 11; o < 16; o++) begin
      req(4'(o), 23'h00_0000, 16'h0000);
      chk({rf, busy}, 2'h2);
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    t_program();
    t_bypass();
    t_accel();
    t_erase();
    t_id_reset();
    t_refuse();
    report_and_stop();
  end
  initial begin
    #3_000_000;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule // fcwr_host_tb
